// >>> design/tmi_irq_enable.sv
// apb register slave holding the event interrupt enables and sticky status
// assumes events are one-cycle pulses from logic on the same clock
module tmi_irq_enable
    import tmi_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire tmi_apb_req_t apb_req,
    output logic              pready,
    output logic              pslverr,
    output logic [31:0]       prdata,
    input  wire tmi_events_t  events,
    output logic              irq
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == TMI_OFF_ENABLE) || (a == TMI_OFF_ENABLE_SET) || (a == TMI_OFF_ENABLE_CLR) ||
                    (a == TMI_OFF_PENDING) || (a == TMI_OFF_PEND_CLR);
    endfunction

    function automatic logic [31:0] evt_vec(input tmi_events_t e);
        logic [31:0] v;
        v = 32'h00000000;
        v[TMI_BIT_HALT]     = e.halt_done_event;
        v[TMI_BIT_ERROR]    = e.error_event;
        v[TMI_BIT_PAUSED]   = e.paused_event;
        v[TMI_BIT_RX_BEGAN] = e.receive_began_event;
        v[TMI_BIT_TX_BEGAN] = e.transmit_began_event;
        v[TMI_BIT_FINAL_IN] = e.final_byte_in_event;
        v[TMI_BIT_FINALOUT] = e.final_byte_out_event;
        evt_vec = v;
    endfunction

    logic [31:0] enable_reg;    // shared enable flops
    logic [31:0] enable_next;   // next enable value
    logic [31:0] pending_reg;   // sticky event status
    logic [31:0] pending_next;  // next status value
    logic [31:0] evt_now;       // this cycle's events in register layout
    logic        wr_take;       // write takes effect this edge
    logic        rd_setup;      // read setup cycle, data captured
    logic [31:0] wmask;         // write data limited to implemented bits

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait-free access phase, data captured in setup
    assign pready   = apb_req.psel & apb_req.penable;                    // answers in first access cycle
    assign pslverr  = pready & ~is_mapped(apb_req.paddr);                // unmapped address flagged
    assign wr_take  = pready & apb_req.pwrite & is_mapped(apb_req.paddr);
    assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign wmask    = apb_req.pwdata & TMI_EVT_MASK;
    assign evt_now  = evt_vec(events) & TMI_EVT_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // enable update; every view edits the same flops
    always_comb begin
        enable_next = enable_reg;
        if (wr_take) begin
            case (apb_req.paddr)
                TMI_OFF_ENABLE:     enable_next = wmask;
                TMI_OFF_ENABLE_SET: enable_next = enable_reg | wmask;
                TMI_OFF_ENABLE_CLR: enable_next = enable_reg & ~wmask;
                default:            enable_next = enable_reg;            // other registers leave it
            endcase
        end
    end

    // enable flops
    always_ff @(posedge clk) begin
        if (reset) begin
            enable_reg <= TMI_RESET_VALUE;
        end else begin
            enable_reg <= enable_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status; an event in the clearing cycle survives the clear
    always_comb begin
        pending_next = pending_reg;
        if (wr_take && apb_req.paddr == TMI_OFF_PEND_CLR) begin
            pending_next = pending_reg & ~wmask;
        end
        pending_next = pending_next | evt_now;                           // set beats clear
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pending_reg <= TMI_RESET_VALUE;
        end else begin
            pending_reg <= pending_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered in the setup cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            case (apb_req.paddr)
                TMI_OFF_ENABLE:     prdata <= enable_reg;
                TMI_OFF_ENABLE_SET: prdata <= enable_reg;
                TMI_OFF_ENABLE_CLR: prdata <= enable_reg;
                TMI_OFF_PENDING:    prdata <= pending_reg;
                default:            prdata <= 32'h00000000;              // write-only and unmapped read zero
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt line: level, high while an enabled event is pending
    assign irq = |(pending_reg & enable_reg);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // a write to the set view; zero bits must leave their enables alone
    sequence set_write_s;
        wr_take && apb_req.paddr == TMI_OFF_ENABLE_SET;
    endsequence

    // a write to the clear view
    sequence clr_write_s;
        wr_take && apb_req.paddr == TMI_OFF_ENABLE_CLR;
    endsequence

    // a write to the plain view, which replaces every enable at once
    sequence enable_write_s;
        wr_take && apb_req.paddr == TMI_OFF_ENABLE;
    endsequence

    // a write that drops sticky status bits
    sequence pend_clr_write_s;
        wr_take && apb_req.paddr == TMI_OFF_PEND_CLR;
    endsequence

    // read of the plain view: setup cycle, then the access cycle that answers
    sequence enable_read_s;
        rd_setup && apb_req.paddr == TMI_OFF_ENABLE ##1 pready;
    endsequence

    // read of the set view
    sequence set_read_s;
        rd_setup && apb_req.paddr == TMI_OFF_ENABLE_SET ##1 pready;
    endsequence

    // read of the clear view
    sequence clr_read_s;
        rd_setup && apb_req.paddr == TMI_OFF_ENABLE_CLR ##1 pready;
    endsequence

    // runs through reset itself, so it opts out of the default disable
    reset_zero_a: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> (enable_reg == 32'h00000000 && !irq))
        else $error("enables not zero after reset");

    // plain view write replaces all implemented enables
    replace_all_a: assert property (enable_write_s |=> enable_reg == $past(wmask))
        else $error("enable write did not replace flags");

    // plain view reads back the shared flops
    enable_read_a: assert property (enable_read_s |-> prdata == enable_reg)
        else $error("enable register read mismatch");

    // enabled event raises irq next cycle unless software writes an enable view or the status clear meanwhile
    event_pass_a: assert property (
        (|(evt_now & enable_reg) && !(wr_take && apb_req.paddr != TMI_OFF_PENDING)) |=> irq)
        else $error("enabled event did not raise irq");

    // no enable, no interrupt, whatever is pending
    event_block_a: assert property ((enable_reg == 32'h00000000) |-> !irq)
        else $error("irq high with no enable");

    // every written one turns its enable on
    set_bits_a: assert property (set_write_s |=> ((enable_reg & $past(wmask)) == $past(wmask)))
        else $error("set write did not enable");

    // a set write never drops an enable already on
    set_keep_a: assert property (set_write_s
        |=> ((enable_reg & $past(enable_reg)) == $past(enable_reg)))
        else $error("set write dropped an enable");

    // an all-zero set write changes nothing
    zero_set_a: assert property (set_write_s and (wmask == 32'h00000000)
        |=> enable_reg == $past(enable_reg))
        else $error("zero set write changed enables");

    // enables move only on a bus write, never on events
    enable_hold_a: assert property (!wr_take |=> enable_reg == $past(enable_reg))
        else $error("enables changed without a write");

    // error and paused are settable together
    err_pause_set_a: assert property (set_write_s and
        (apb_req.pwdata[TMI_BIT_ERROR] && apb_req.pwdata[TMI_BIT_PAUSED])
        |=> enable_reg[TMI_BIT_ERROR] && enable_reg[TMI_BIT_PAUSED])
        else $error("error or paused enable not set");

    // set view reads back the present enables
    set_read_a: assert property (set_read_s |-> prdata == enable_reg)
        else $error("set register read mismatch");

    // every written one turns its enable off
    clr_bits_a: assert property (clr_write_s |=> ((enable_reg & $past(wmask)) == 32'h00000000))
        else $error("clear write did not disable");

    // bits written as zero keep their enables through a clear
    clr_keep_a: assert property (clr_write_s
        |=> (enable_reg & ~$past(wmask)) == ($past(enable_reg) & ~$past(wmask)))
        else $error("clear write disturbed other enables");

    // clear view reads back the present enables
    clear_read_a: assert property (clr_read_s |-> prdata == enable_reg)
        else $error("clear register read mismatch");

    // last byte sent is recorded in status
    final_evt_a: assert property (events.final_byte_out_event
        |=> pending_reg[TMI_BIT_FINALOUT])
        else $error("final byte out event not recorded");

    // last byte received is recorded in status
    final_in_a: assert property (events.final_byte_in_event
        |=> pending_reg[TMI_BIT_FINAL_IN])
        else $error("final byte in event not recorded");

    // a status clear drops written bits unless the same event lands again
    pend_clear_a: assert property (pend_clr_write_s
        |=> (pending_reg & $past(wmask) & ~$past(evt_now)) == 32'h00000000)
        else $error("status clear left bits set");

    // unmapped reads are flagged and return zero
    unmapped_a: assert property (rd_setup && !is_mapped(apb_req.paddr) ##1 pready
        |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped read not refused");

endmodule // tmi_irq_enable

// >>> design/tmi_pkg.sv
// constants and carrier types for the two-wire master interrupt-enable block
// assumes a 40 MHz apb clock shared with the bus engine that raises the events
package tmi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] TMI_OFF_ENABLE     = 12'h300;  // read/write enable view
    localparam logic [11:0] TMI_OFF_ENABLE_SET = 12'h304;  // write-one-to-set view
    localparam logic [11:0] TMI_OFF_ENABLE_CLR = 12'h308;  // write-one-to-clear view
    localparam logic [11:0] TMI_OFF_PENDING    = 12'h310;  // sticky event status, read only
    localparam logic [11:0] TMI_OFF_PEND_CLR   = 12'h314;  // status clear, write only

    ////////////////////////////////////////////////////////////////////////////
    // field positions, one per event
    localparam int TMI_BIT_HALT     = 1;
    localparam int TMI_BIT_ERROR    = 9;
    localparam int TMI_BIT_PAUSED   = 18;
    localparam int TMI_BIT_RX_BEGAN = 19;
    localparam int TMI_BIT_TX_BEGAN = 20;
    localparam int TMI_BIT_FINAL_IN = 23;
    localparam int TMI_BIT_FINALOUT = 24;

    // implemented bits; all others read as zero
    localparam logic [31:0] TMI_EVT_MASK    = 32'h019C0202;
    localparam logic [31:0] TMI_RESET_VALUE = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic        halt_done_event;       // engine halted
        logic        error_event;           // bus error seen
        logic        paused_event;          // engine paused
        logic        receive_began_event;   // receive started
        logic        transmit_began_event;  // transmit started
        logic        final_byte_in_event;   // last byte begins to be received
        logic        final_byte_out_event;  // last byte begins to be sent
    } tmi_events_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tmi_apb_req_t;

endpackage : tmi_pkg

// >>> sim/tb_top.sv
// self-checking bench for the event interrupt-enable register block
// assumes the block is the only apb slave and events come from the same clock
module tb_top
    import tmi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk;      // 40 MHz bus clock
    logic         reset;    // synchronous, active high
    tmi_apb_req_t req;      // apb request bundle
    tmi_events_t  events;   // one-cycle event pulses
    logic         pready;   // slave ready
    logic         pslverr;  // slave error
    logic [31:0]  prdata;   // read data
    logic         irq;      // level interrupt
    logic [31:0]  rd;       // last read word
    logic         err;      // last error flag
    logic [31:0]  acc;      // expected enables
    int           n_errors;
    int           checks;
    // register bit for each event, indexed by its struct bit (halt is msb)
    int           pos[7] = '{TMI_BIT_FINALOUT, TMI_BIT_FINAL_IN, TMI_BIT_TX_BEGAN, TMI_BIT_RX_BEGAN,
                             TMI_BIT_PAUSED, TMI_BIT_ERROR, TMI_BIT_HALT};

    tmi_irq_enable tmi_irq_enable_inst (.clk(clk), .reset(reset), .apb_req(req), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .events(events), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    // clock, never stops until finish
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; assumes no wait count, only the watchdog ends a hung wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // pulse one event for a single cycle, then let the irq settle
    task automatic pulse(input int i);
        @(posedge clk);
        events <= tmi_events_t'(7'(1) << i);
        @(posedge clk);
        events <= '0;
        #1;
    endtask

    task automatic summarize();
        $display("errors %0d, checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        n_errors = 0;
        checks = 0;
        req = '0;
        events = '0;
        reset = 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, TMI_OFF_ENABLE, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b1, TMI_OFF_ENABLE, 32'hFFFFFFFF);
        apb(1'b0, TMI_OFF_ENABLE, 32'h0);
        chk(rd, TMI_EVT_MASK);
        apb(1'b1, TMI_OFF_ENABLE_CLR, 32'hFFFFFFFF);
        apb(1'b0, TMI_OFF_ENABLE_CLR, 32'h0);
        chk(rd, 32'h00000000);
        // set one flag at a time; earlier flags must survive the zero bits
        acc = 32'h0;
        for (int i = 6; i >= 0; i--) begin
            acc[pos[i]] = 1'b1;
            apb(1'b1, TMI_OFF_ENABLE_SET, 32'(1) << pos[i]);
            apb(1'b0, TMI_OFF_ENABLE_SET, 32'h0);
            chk(rd, acc);
        end
        apb(1'b1, TMI_OFF_ENABLE_SET, 32'h0);
        apb(1'b0, TMI_OFF_ENABLE, 32'h0);
        chk(rd, acc);
        apb(1'b0, TMI_OFF_ENABLE_SET, 32'h0);
        chk(rd, acc);
        // error and paused set together in one write
        apb(1'b1, TMI_OFF_ENABLE_CLR, 32'hFFFFFFFF);
        apb(1'b1, TMI_OFF_ENABLE_SET, (32'(1) << TMI_BIT_ERROR) | (32'(1) << TMI_BIT_PAUSED));
        apb(1'b0, TMI_OFF_ENABLE, 32'h0);
        chk(rd, (32'(1) << TMI_BIT_ERROR) | (32'(1) << TMI_BIT_PAUSED));
        // every event: blocked while disabled, passed once set, blocked after clear
        apb(1'b1, TMI_OFF_ENABLE_CLR, 32'hFFFFFFFF);
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            chk({31'h0, irq}, 32'h0);
            apb(1'b0, TMI_OFF_PENDING, 32'h0);
            chk(rd, 32'(1) << pos[i]);
            apb(1'b1, TMI_OFF_ENABLE_SET, 32'(1) << pos[i]);
            #1;
            chk({31'h0, irq}, 32'h1);
            // drop the status, then the event must pass while enabled
            apb(1'b1, TMI_OFF_PEND_CLR, 32'hFFFFFFFF);
            #1;
            chk({31'h0, irq}, 32'h0);
            pulse(i);
            chk({31'h0, irq}, 32'h1);
            apb(1'b1, TMI_OFF_ENABLE_CLR, 32'(1) << pos[i]);
            #1;
            chk({31'h0, irq}, 32'h0);
            apb(1'b1, TMI_OFF_PEND_CLR, 32'hFFFFFFFF);
        end
        // reset in mid-run must drop enables set beforehand
        apb(1'b1, TMI_OFF_ENABLE, 32'hFFFFFFFF);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, TMI_OFF_ENABLE, 32'h0);
        chk(rd, TMI_RESET_VALUE);
        // unmapped place answers with an error and reads zero
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h00000000);
        summarize();
    end
endmodule // tb_top
